// [rcp_cfg.svh]
/*
 * Constants of the receive cell/packet system port: register offsets,
 * field positions, reset values and FIFO geometry.
 * Assumes it is included once per compile unit by its bare name.
 */
`ifndef RCP_CFG_SVH
`define RCP_CFG_SVH

// ==========================================================
// FIFO geometry
`define RCP_NCH         4
`define RCP_CH_W        2
`define RCP_FIFO_BYTES  1024
`define RCP_DEPTH       (`RCP_FIFO_BYTES / 4)
`define RCP_PTR_W       8
`define RCP_CNT_W       9
`define RCP_CELL_LIMIT  16
`define RCP_CELL_WORDS  13
`define RCP_L2_CELLS    4

// ==========================================================
// Register offsets
`define RCP_REG_CTRL    8'h00
`define RCP_REG_THRESH  8'h04
`define RCP_REG_OVR     8'h08
`define RCP_REG_MASK    8'h0c
`define RCP_REG_STATE   8'h10

// ==========================================================
// Field positions and reset values
`define RCP_CTRL_ODD    2
`define RCP_CTRL_RCASEL 3
`define RCP_THR_NE_LSB  16
`define RCP_CTRL_RST    32'h0000_0000
`define RCP_THRESH_RST  32'h0004_0040

`endif

// [rcp_link_model.sv]
/*
 * Link layer model: makes the 170 ns read clock, read enable and address.
 * Assumes clock_i is the 100 MHz system clock; the link clock idles low.
 */
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Link layer
module rcp_link_model (
    input  wire logic       clock_i,
    output logic            rfclk_o,
    output logic            renb_n_o,
    output logic      [3:0] radr_o
);
    initial begin
        rfclk_o = 1'b0;
        renb_n_o = 1'b1;
        radr_o = 4'h0;
    end

    // Poll fill status without clocking the link
    task automatic poll(input logic [3:0] adr);
        @(posedge clock_i);
        radr_o <= adr;
    endtask

    // One link clock period; inputs held across the whole period
    task automatic cycle(input logic en_n, input logic [3:0] adr);
        @(posedge clock_i);
        renb_n_o <= en_n; // Falling enable selects the address
        radr_o <= adr;
        repeat (8) @(posedge clock_i);
        rfclk_o <= 1'b1;
        repeat (8) @(posedge clock_i);
        rfclk_o <= 1'b0;
    endtask
endmodule // rcp_link_model

`default_nettype wire

// [rcp_pkg.sv]
/*
 * Types of the receive cell/packet system port.
 * Assumes rcp_cfg.svh supplies the numeric constants.
 */
`default_nettype none

package rcp_pkg;
    // Interface personality, in the order of the mode field codes
    typedef enum logic [1:0] {
        RCP_UL2,
        RCP_PL2,
        RCP_UL3,
        RCP_PL3
    } rcp_mode_e;

    // Packet valid session of the selected channel
    typedef enum logic [1:0] {
        RCP_IDLE,
        RCP_ARMED,
        RCP_STREAM,
        RCP_SPENT
    } rcp_sess_e;
endpackage

`default_nettype wire

// [rcp_rx_port.sv]
/*
 * Receive system port: per-channel receive FIFOs in flip-flops, a framer
 * side write port, a link side read port sampled from the link read clock,
 * and a small register file.
 * Assumes the link clock is far slower than clock_i (at least 4x) and that
 * the framer never writes more than one word per clock.
 */
`timescale 1ns/10ps
`default_nettype none
`include "rcp_cfg.svh"

// Behaviour
// - Cell level 2: RCA unavailable at empty (select high) or near empty (low).
// - Reading while RCA is low yields meaningless held data.
// - Overrun in cell level 2 flushes that channel FIFO, losing cells.
// - Every overrun sets a status bit and a maskable interrupt.
// - Data and start marker change on rising edges of the link clock.
// - Packet level 2: RPA once threshold bytes or an end are buffered.
// - Parity output covers the data bus, odd or even by configuration.
// - 16-bit mode: RMOD with REOP tells one or two valid bytes.
// - RERR marks errored packets, aborts and frame check failures.
// - RVAL rises on transfer start only with RPA; holds to empty or end.
// - After RVAL falls it stays low until a fresh port selection.
// - Cell level 3: each channel FIFO holds up to sixteen cells.
// - Level 3: address polls RCA (cell) or RPA (packet); selection at read enable falling edge.
// - Cell level 3: 32-bit data, start marker on first word.
// - Packet level 3: each channel FIFO holds 1024 bytes.
// - Packet level 3: start marker on first word of packet.
// - Packet level 3: REOP on last word, 2-bit RMOD gives valid bytes.
// - Packet level 3: RVAL qualifies markers, error, RMOD and data.
// - Reads while RVAL is low are ignored.
// - RVAL never rises before read enable is asserted.
module rcp_rx_port
    import rcp_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        reset_n_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    input  wire logic        wr_valid_i,
    input  wire logic [1:0]  wr_chan_i,
    input  wire logic [31:0] wr_data_i,
    input  wire logic        wr_sop_i,
    input  wire logic        wr_eop_i,
    input  wire logic        wr_err_i,
    input  wire logic [1:0]  wr_mod_i,
    input  wire logic        rfclk_i,
    input  wire logic        renb_n_i,
    input  wire logic [3:0]  radr_i,
    output logic      [31:0] rdat_o,
    output logic             rprty_o,
    output logic             rsoc_o,
    output logic             reop_o,
    output logic      [1:0]  rmod_o,
    output logic             rerr_o,
    output logic             rval_o,
    output logic             rca_o,
    output logic             rpa_o,
    output logic             irq_o
);

    localparam int NCH = `RCP_NCH;

    // ==========================================================
    // Link input synchronisers
    logic       rfclk_s1, rfclk_s2, rfclk_s3;
    logic       renb_n_s1, renb_n_s2;
    logic [3:0] radr_s1, radr_s2;
    logic       link_edge;

    // Two flops per link input; the third rfclk flop only finds the edge
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rfclk_s1  <= 1'b0;
            rfclk_s2  <= 1'b0;
            rfclk_s3  <= 1'b0;
            renb_n_s1 <= 1'b1;
            renb_n_s2 <= 1'b1;
            radr_s1   <= 4'h0;
            radr_s2   <= 4'h0;
        end else begin
            rfclk_s1  <= rfclk_i;
            rfclk_s2  <= rfclk_s1;
            rfclk_s3  <= rfclk_s2;
            renb_n_s1 <= renb_n_i;
            renb_n_s2 <= renb_n_s1;
            radr_s1   <= radr_i;
            radr_s2   <= radr_s1;
        end
    end

    assign link_edge = rfclk_s2 & ~rfclk_s3;

    // ==========================================================
    // Registers
    logic [31:0]    ctrl, thresh;
    logic [NCH-1:0] ovr, mask, ovr_ev;
    logic [31:0]    next_ctrl, next_thresh, next_rdata;
    logic [NCH-1:0] next_ovr, next_mask;
    logic           next_irq;
    rcp_mode_e      mode;
    logic           is_pos, is_l2;
    logic [`RCP_CNT_W-1:0] cap, near;
    logic [11:0]    rpa_thr;
    logic [31:0]    state_word;

    assign mode    = rcp_mode_e'(ctrl[1:0]);
    assign is_pos  = (mode == RCP_PL2) || (mode == RCP_PL3);
    assign is_l2   = (mode == RCP_UL2) || (mode == RCP_PL2);
    assign near    = thresh[`RCP_THR_NE_LSB +: `RCP_CNT_W];
    assign rpa_thr = {2'b00, thresh[9:0]};
    // Cell modes cap the FIFO at whole cells so a full FIFO is cell aligned;
    // level 2 keeps four cells, so an overrun flush never loses more
    assign cap     = is_pos ? `RCP_CNT_W'(`RCP_DEPTH)
                   : (mode == RCP_UL2) ? `RCP_CNT_W'(`RCP_L2_CELLS * `RCP_CELL_WORDS)
                   : `RCP_CNT_W'(`RCP_CELL_LIMIT * `RCP_CELL_WORDS);

    // Register writes, overrun status, read data
    always_comb begin
        next_ctrl   = ctrl;
        next_thresh = thresh;
        next_mask   = mask;
        next_ovr    = ovr;
        next_rdata  = 32'h0000_0000;
        if (wr_i) begin
            unique case (addr_i)
                `RCP_REG_CTRL:   next_ctrl   = {28'h0000000, wdata_i[3:0]};
                `RCP_REG_THRESH: next_thresh = wdata_i & 32'h01ff_03ff;
                `RCP_REG_OVR:    next_ovr    = ovr & ~wdata_i[NCH-1:0];
                `RCP_REG_MASK:   next_mask   = wdata_i[NCH-1:0];
                default: ;
            endcase
        end
        // A new overrun in the clearing cycle is kept
        next_ovr = next_ovr | ovr_ev;
        if (rd_i) begin
            unique case (addr_i)
                `RCP_REG_CTRL:   next_rdata = ctrl;
                `RCP_REG_THRESH: next_rdata = thresh;
                `RCP_REG_OVR:    next_rdata = {28'h0000000, ovr};
                `RCP_REG_MASK:   next_rdata = {28'h0000000, mask};
                `RCP_REG_STATE:  next_rdata = state_word;
                default:         next_rdata = 32'h0000_0000;
            endcase
        end
        next_irq = |(ovr & mask);
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl    <= `RCP_CTRL_RST;
            thresh  <= `RCP_THRESH_RST;
            ovr     <= '0;
            mask    <= '0;
            rdata_o <= 32'h0000_0000;
            irq_o   <= 1'b0;
        end else begin
            ctrl    <= next_ctrl;
            thresh  <= next_thresh;
            ovr     <= next_ovr;
            mask    <= next_mask;
            rdata_o <= next_rdata;
            irq_o   <= next_irq;
        end
    end

    // ==========================================================
    // Channel FIFOs
    logic [36:0]           mem [NCH * `RCP_DEPTH];
    logic [`RCP_PTR_W-1:0] wp [NCH];
    logic [`RCP_PTR_W-1:0] rp [NCH];
    logic [`RCP_CNT_W-1:0] cnt [NCH];
    logic [`RCP_CNT_W-1:0] eopc [NCH];
    logic [NCH-1:0]        dropping, full_v;
    logic                  pop, wr_ok;
    logic [`RCP_CH_W-1:0]  sel;
    logic [36:0]           head;

    assign wr_ok = wr_valid_i && !full_v[wr_chan_i];
    assign head  = mem[{sel, rp[sel]}];

    // Words carry err, sop, eop, mod and data; a packet cut by overrun
    // is closed with its error bit so the link can drop it
    always_ff @(posedge clock_i) begin
        if (wr_ok) begin
            mem[{wr_chan_i, wp[wr_chan_i]}] <= {wr_err_i | dropping[wr_chan_i],
                                               wr_sop_i, wr_eop_i, wr_mod_i, wr_data_i};
        end
    end

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        logic                  wr_hit, rd_hit;
        logic [`RCP_PTR_W-1:0] next_wp, next_rp;
        logic [`RCP_CNT_W-1:0] next_cnt, next_eopc;
        logic                  next_drop;

        assign full_v[c] = cnt[c] >= cap;
        assign wr_hit    = wr_valid_i && (wr_chan_i == `RCP_CH_W'(c));
        assign rd_hit    = pop && (sel == `RCP_CH_W'(c));
        assign ovr_ev[c] = wr_hit && full_v[c];

        // Pointer, fill and end-of-packet bookkeeping
        always_comb begin
            next_wp   = wp[c];
            next_rp   = rp[c];
            next_cnt  = cnt[c];
            next_eopc = eopc[c];
            next_drop = dropping[c];
            if (ovr_ev[c] && mode == RCP_UL2) begin
                next_wp   = '0;
                next_rp   = '0;
                next_cnt  = '0;
                next_eopc = '0;
                next_drop = 1'b0;
            end else begin
                if (wr_hit && !full_v[c]) begin
                    next_wp  = wp[c] + 1'b1;
                    next_cnt = next_cnt + 1'b1;
                    if (wr_eop_i) begin
                        next_eopc = next_eopc + 1'b1;
                        next_drop = 1'b0;
                    end
                end
                if (ovr_ev[c] && is_pos) begin
                    next_drop = 1'b1;
                end
                if (rd_hit) begin
                    next_rp  = rp[c] + 1'b1;
                    next_cnt = next_cnt - 1'b1;
                    if (head[34]) begin
                        next_eopc = next_eopc - 1'b1;
                    end
                end
            end
        end

        always_ff @(posedge clock_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                wp[c]       <= '0;
                rp[c]       <= '0;
                cnt[c]      <= '0;
                eopc[c]     <= '0;
                dropping[c] <= 1'b0;
            end else begin
                wp[c]       <= next_wp;
                rp[c]       <= next_rp;
                cnt[c]      <= next_cnt;
                eopc[c]     <= next_eopc;
                dropping[c] <= next_drop;
            end
        end
    end

    // ==========================================================
    // Link read side
    rcp_sess_e            sess, next_sess;
    logic                 renb_last, next_renb_last, half, next_half;
    logic [`RCP_CH_W-1:0] next_sel, pc;
    logic                 polled_ok, rpa_sel, xfer, short_eop, last;
    logic [31:0]          next_rdat;
    logic                 next_rsoc, next_reop, next_rerr, next_rval;
    logic                 next_rca, next_rpa, next_rprty;
    logic [1:0]           next_rmod;

    assign pc         = radr_s2[`RCP_CH_W-1:0];
    assign polled_ok  = radr_s2 < 4'(NCH);
    assign rpa_sel    = ({1'b0, cnt[sel], 2'b00} >= rpa_thr) || (eopc[sel] != '0);
    // Upper half of a word that ends with at most two valid bytes
    assign short_eop  = head[34] && head[33];
    assign state_word = {24'h000000, rval_o, half, sess, 2'b00, sel};

    always_comb begin
        next_sess      = sess;
        next_sel       = sel;
        next_half      = half;
        next_renb_last = renb_last;
        next_rdat      = rdat_o;
        next_rsoc      = rsoc_o;
        next_reop      = reop_o;
        next_rmod      = rmod_o;
        next_rerr      = rerr_o;
        next_rval      = rval_o;
        xfer           = 1'b0;
        pop            = 1'b0;
        last           = 1'b0;
        if (link_edge) begin
            next_renb_last = renb_n_s2;
            if (!renb_n_s2 && renb_last) begin
                // Selection edge: take the address, rearm the valid
                next_sel  = pc;
                next_sess = RCP_ARMED;
                next_half = 1'b0;
                next_rval = 1'b0;
            end else if (!renb_n_s2) begin
                if (!is_pos) begin
                    xfer = cnt[sel] != '0;
                end else begin
                    unique case (sess)
                        RCP_ARMED:  xfer = rpa_sel && (cnt[sel] != '0);
                        RCP_STREAM: xfer = cnt[sel] != '0;
                        default:    xfer = 1'b0;
                    endcase
                    if (sess == RCP_STREAM && cnt[sel] == '0) begin
                        next_sess = RCP_SPENT;
                    end
                end
            end
        end
        if (xfer) begin
            if (is_l2) begin
                pop       = half || short_eop;
                last      = half ? head[34] : short_eop;
                next_half = !pop;
                next_rdat = {16'h0000, half ? head[15:0] : head[31:16]};
                // One valid byte: code 11 up top, or three in all below
                next_rmod = {1'b0, half ? (head[33:32] == 2'b01)
                                        : (head[33:32] == 2'b11)};
                next_rsoc = head[35] && !half;
            end else begin
                pop       = 1'b1;
                last      = head[34];
                next_rdat = head[31:0];
                next_rmod = head[33:32];
                next_rsoc = head[35];
            end
            next_reop = last;
            next_rerr = head[36] && last;
            next_rval = is_pos;
            if (is_pos) begin
                next_sess = last ? RCP_SPENT : RCP_STREAM;
            end
        end else if (link_edge && !renb_n_s2) begin
            next_rval = 1'b0;
        end
        next_rprty = ^next_rdat ^ ctrl[`RCP_CTRL_ODD];
        // Poll status of the addressed channel
        if (!is_pos) begin
            if (mode == RCP_UL3) begin
                next_rca = polled_ok &&
                           (cnt[pc] >= `RCP_CNT_W'(`RCP_CELL_WORDS));
            end else begin
                next_rca = polled_ok && (ctrl[`RCP_CTRL_RCASEL] ? (cnt[pc] != '0)
                                                                : (cnt[pc] > near));
            end
            next_rpa = 1'b0;
        end else begin
            next_rca = 1'b0;
            next_rpa = polled_ok && (({1'b0, cnt[pc], 2'b00} >= rpa_thr) ||
                                     (eopc[pc] != '0));
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sess      <= RCP_IDLE;
            sel       <= '0;
            half      <= 1'b0;
            renb_last <= 1'b1;
            rdat_o    <= 32'h0000_0000;
            rprty_o   <= 1'b0;
            rsoc_o    <= 1'b0;
            reop_o    <= 1'b0;
            rmod_o    <= 2'b00;
            rerr_o    <= 1'b0;
            rval_o    <= 1'b0;
            rca_o     <= 1'b0;
            rpa_o     <= 1'b0;
        end else begin
            sess      <= next_sess;
            sel       <= next_sel;
            half      <= next_half;
            renb_last <= next_renb_last;
            rdat_o    <= next_rdat;
            rprty_o   <= next_rprty;
            rsoc_o    <= next_rsoc;
            reop_o    <= next_reop;
            rmod_o    <= next_rmod;
            rerr_o    <= next_rerr;
            rval_o    <= next_rval;
            rca_o     <= next_rca;
            rpa_o     <= next_rpa;
        end
    end

endmodule // rcp_rx_port

`default_nettype wire

// [rcp_rx_port_sva.sv]
/*
 * Assertion checker for the receive system port, bound to rcp_rx_port.
 * Assumes ctrl and mask change only through bus writes.
 */
`timescale 1ns/10ps
`default_nettype none
`include "rcp_cfg.svh"

// ==========================================================
// Checker
module rcp_rx_port_sva (
    input wire logic        clock_i,
    input wire logic        reset_n_i,
    input wire logic [7:0]  addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic        rfclk_i,
    input wire logic        renb_n_i,
    input wire logic [3:0]  radr_i,
    input wire logic [31:0] rdat_o,
    input wire logic        rprty_o,
    input wire logic        reop_o,
    input wire logic        rerr_o,
    input wire logic        rval_o,
    input wire logic        rca_o,
    input wire logic        rpa_o,
    input wire logic        irq_o
);
    logic [3:0] ctrl;
    logic [3:0] mask;
    logic [3:0] since_rise;
    logic       rf_q;
    logic       rv_q;
    logic       spent;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    // Shadow the bus writes, since the design's own registers are hidden
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl       <= 4'h0;
            mask       <= 4'h0;
            since_rise <= 4'hf;
            rf_q       <= 1'b0;
            rv_q       <= 1'b0;
            spent      <= 1'b0;
        end else begin
            if (wr_i && addr_i == `RCP_REG_CTRL) ctrl <= wdata_i[3:0];
            if (wr_i && addr_i == `RCP_REG_MASK) mask <= wdata_i[3:0];
            since_rise <= (rfclk_i && !rf_q) ? 4'h0 : since_rise + {3'h0, since_rise != 4'hf};
            rf_q <= rfclk_i;
            rv_q <= rval_o;
            if (rv_q && !rval_o) spent <= 1'b1;
            else if (renb_n_i) spent <= 1'b0;
        end
    end

    AST_PARITY: assert property (rval_o |-> rprty_o == (^rdat_o ^ ctrl[2]))
        else $error("parity does not match data");
    AST_RVAL_RENB: assert property ($rose(rval_o) |-> !renb_n_i)
        else $error("valid rose without read enable");
    AST_RVAL_MODE: assert property (!ctrl[0] |-> !rval_o)
        else $error("valid high in a cell mode");
    AST_ERR_ON_EOP: assert property (rerr_o |-> reop_o)
        else $error("error flag away from end of packet");
    AST_RVAL_HOLD: assert property ($fell(rval_o) |-> $past(reop_o) || !renb_n_i)
        else $error("valid fell mid packet while idle");
    AST_RVAL_SPENT: assert property (spent |-> !rval_o)
        else $error("valid back without reselection");
    AST_RCA_UNMAPPED: assert property ((radr_i[3:2] != 2'b00) [*6] |-> !rca_o && !rpa_o)
        else $error("missing channel reported available");
    AST_IRQ_MASK: assert property (mask == 4'h0 && $past(mask) == 4'h0 |-> !irq_o)
        else $error("interrupt with all sources masked");
    AST_RDATA_IDLE: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data outside the answer cycle");
    AST_OUT_ON_RFCLK: assert property ($changed(rdat_o) |-> since_rise <= 4'd8)
        else $error("data changed away from a link clock rise");
endmodule // rcp_rx_port_sva

bind rcp_rx_port rcp_rx_port_sva rcp_rx_port_sva_i (.*);

`default_nettype wire

// [rcp_rx_port_tb.sv]
/*
 * Self-checking bench of rcp_rx_port with a queue model of the FIFO.
 * Assumes rcp_link_model drives the link side.
 */
`timescale 1ns/10ps
`default_nettype none
`include "rcp_cfg.svh"

`define CHK(nm, ex, got) begin \
    total_checks++; \
    if ((got) !== (ex)) begin \
        failures++; \
        $display("Error %s expected %h seen %h", nm, ex, got); \
    end \
end

// ==========================================================
// Bench
module rcp_rx_port_tb;
    logic        clock_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic [7:0]  addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        wr_valid_i = 1'b0;
    logic [1:0]  wr_chan_i = 2'h0;
    logic [31:0] wr_data_i = 32'h0;
    logic        wr_sop_i = 1'b0;
    logic        wr_eop_i = 1'b0;
    logic        wr_err_i = 1'b0;
    logic [1:0]  wr_mod_i = 2'h0;
    logic [31:0] rdata_o;
    logic        rfclk_i;
    logic        renb_n_i;
    logic [3:0]  radr_i;
    logic [31:0] rdat_o;
    logic [1:0]  rmod_o;
    logic        rprty_o, rsoc_o, reop_o, rerr_o, rval_o, rca_o, rpa_o, irq_o;
    int          failures = 0;
    int          total_checks = 0;
    logic [36:0] exp_q[$];
    logic [31:0] rst_v[6] = '{32'h0, `RCP_THRESH_RST, 32'h0, 32'h0, 32'h0, 32'h0};

    always #5 clock_i = ~clock_i;

    rcp_rx_port rcp_rx_port_i (.*);
    rcp_link_model rcp_link_model_i (
        .clock_i  (clock_i),
        .rfclk_o  (rfclk_i),
        .renb_n_o (renb_n_i),
        .radr_o   (radr_i)
    );

    // Bus cycles, one strobe cycle each
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] ex);
        @(posedge clock_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        `CHK("rdata", ex, rdata_o)
    endtask

    // Framer word, back to back; the model queue mirrors the FIFO
    task automatic push(input logic [1:0] ch, input logic s, e, er, input logic [1:0] m);
        logic [31:0] d;
        d = $urandom;
        @(posedge clock_i);
        wr_valid_i <= 1'b1;
        wr_chan_i <= ch;
        wr_data_i <= d;
        wr_sop_i <= s;
        wr_eop_i <= e;
        wr_err_i <= er;
        wr_mod_i <= m;
        exp_q.push_back({s, e, er, m, d});
    endtask

    task automatic settle(input int n);
        @(posedge clock_i);
        wr_valid_i <= 1'b0;
        repeat (n) @(posedge clock_i);
    endtask

    // Deselect, then select channel 1; the selection edge moves no data
    task automatic select_ch1();
        rcp_link_model_i.cycle(1'b1, 4'h1);
        rcp_link_model_i.cycle(1'b0, 4'h1);
        `CHK("rval_select", 1'b0, rval_o)
    endtask

    task automatic link_read(input logic ev, input logic odd);
        logic [36:0] w;
        rcp_link_model_i.cycle(1'b0, 4'h1);
        `CHK("rval", ev, rval_o)
        if (ev) begin // Data only counts while valid
            w = exp_q.pop_front();
            `CHK("rdat", w[31:0], rdat_o)
            `CHK("rsoc", w[36], rsoc_o)
            `CHK("reop", w[35], reop_o)
            `CHK("rprty", ^w[31:0] ^ odd, rprty_o)
            if (w[35]) begin
                `CHK("rerr", w[34], rerr_o)
                `CHK("rmod", w[33:32], rmod_o)
            end
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Tests
    initial begin
        void'($urandom(45));
        repeat (12) @(posedge clock_i);
        reset_n_i <= 1'b1;
        // Read-only and unmapped writes must leave the reset values alone
        reg_wr(8'h10, 32'hffff_ffff);
        reg_wr(8'h14, 32'hffff_ffff);
        foreach (rst_v[i]) reg_rd(8'(i * 4), rst_v[i]);
        // Cell level 2: availability select, then overrun flush at 53 words
        reg_wr(`RCP_REG_CTRL, 32'h8);
        rcp_link_model_i.poll(4'h5);
        settle(8);
        `CHK("rca_unmapped", 1'b0, rca_o)
        rcp_link_model_i.poll(4'h0);
        repeat (3) push(2'h0, 1'b0, 1'b0, 1'b0, 2'h0);
        settle(8);
        `CHK("rca_not_empty", 1'b1, rca_o)
        reg_wr(`RCP_REG_CTRL, 32'h0);
        settle(8);
        `CHK("rca_near_empty", 1'b0, rca_o)
        repeat (49) push(2'h0, 1'b0, 1'b0, 1'b0, 2'h0);
        settle(8);
        `CHK("rca_full", 1'b1, rca_o)
        reg_rd(`RCP_REG_OVR, 32'h0);
        push(2'h0, 1'b0, 1'b0, 1'b0, 2'h0);
        settle(8);
        `CHK("rca_flushed", 1'b0, rca_o)
        reg_rd(`RCP_REG_OVR, 32'h1);
        `CHK("irq_masked", 1'b0, irq_o)
        reg_wr(`RCP_REG_MASK, 32'h1);
        settle(2);
        `CHK("irq", 1'b1, irq_o)
        reg_wr(`RCP_REG_OVR, 32'h1);
        settle(2);
        `CHK("irq_clear", 1'b0, irq_o)
        // Packet level 3, even then odd parity; all four byte codes
        exp_q.delete();
        for (int odd = 0; odd < 2; odd++) begin
            reg_wr(`RCP_REG_CTRL, 32'(3 + 4 * odd));
            rcp_link_model_i.poll(4'h1);
            push(2'h1, 1'b1, 1'b0, 1'b0, 2'h0);
            push(2'h1, 1'b0, 1'b0, 1'b0, 2'h0);
            push(2'h1, 1'b0, 1'b1, odd[0], 2'(2 * odd));
            push(2'h1, 1'b1, 1'b0, 1'b0, 2'h0);
            push(2'h1, 1'b0, 1'b1, ~odd[0], 2'(2 * odd + 1));
            settle(8);
            `CHK("rpa", 1'b1, rpa_o)
            select_ch1();
            repeat (3) link_read(1'b1, odd[0]);
            link_read(1'b0, odd[0]);
            select_ch1();
            repeat (2) link_read(1'b1, odd[0]);
            link_read(1'b0, odd[0]);
        end
        // Cell level 3: a cell shows from its thirteenth word; sixteen cells fit
        reg_wr(`RCP_REG_CTRL, 32'h2);
        rcp_link_model_i.poll(4'h2);
        push(2'h2, 1'b1, 1'b0, 1'b0, 2'h0);
        repeat (11) push(2'h2, 1'b0, 1'b0, 1'b0, 2'h0);
        settle(8);
        `CHK("rca_part_cell", 1'b0, rca_o)
        push(2'h2, 1'b0, 1'b0, 1'b0, 2'h0);
        settle(8);
        `CHK("rca_cell", 1'b1, rca_o)
        rcp_link_model_i.cycle(1'b1, 4'h2);
        rcp_link_model_i.cycle(1'b0, 4'h2);
        rcp_link_model_i.cycle(1'b0, 4'h2);
        `CHK("cell_rdat", exp_q[0][31:0], rdat_o)
        `CHK("cell_rsoc", 1'b1, rsoc_o)
        `CHK("cell_rval", 1'b0, rval_o)
        repeat (196) push(2'h2, 1'b0, 1'b0, 1'b0, 2'h0);
        settle(8);
        reg_rd(`RCP_REG_OVR, 32'h0);
        push(2'h2, 1'b0, 1'b0, 1'b0, 2'h0);
        settle(8);
        reg_rd(`RCP_REG_OVR, 32'h4);
        report_and_stop();
    end

    // Cut a hang short; the tests need well under 50 us
    initial begin
        #200_000;
        failures++;
        report_and_stop();
    end
endmodule // rcp_rx_port_tb

`undef CHK
`default_nettype wire
